// ==== hdl/npc_pkg.sv ====
// Purpose: Shared constants for the network config register bank
// Assumes: 10 MHz clock, Avalon-MM byte addresses, 16-bit registers
// Notes:   Register byte address is four times its index
package npc_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          REG_W        = 16;
  localparam int          BE_W         = 4;
  // Register indexes
  localparam logic [5:0]  IDX_FLOOR    = 6'h0D;
  localparam logic [5:0]  IDX_SLEEP    = 6'h0E;
  localparam logic [5:0]  IDX_PHY      = 6'h0F;
  localparam logic [5:0]  IDX_CTRL     = 6'h3F;
  // Writable field masks, reserved bits cleared
  localparam logic [15:0] MASK_FLOOR   = 16'h007F;
  localparam logic [15:0] MASK_SLEEP   = 16'h000F;
  localparam logic [15:0] MASK_PHY     = 16'h8703;
  localparam logic [15:0] MASK_CTRL    = 16'h0001;
  // Reset values
  localparam logic [15:0] RST_FLOOR    = 16'h0000;
  localparam logic [15:0] RST_SLEEP    = 16'h0000;
  localparam logic [15:0] RST_PHY      = 16'h0400;
  localparam logic [15:0] RST_CTRL     = 16'h0000;
  // Field positions
  localparam int          FLOOR_MSB    = 6;
  localparam int          EXP_MSB      = 3;
  localparam int          NEG_OFF_BIT  = 15;
  localparam int          ANEG_MSB     = 10;
  localparam int          ANEG_LSB     = 8;
  localparam int          FIX_MSB      = 1;
  localparam int          ALLOW_BIT    = 0;
  localparam int          ST_SLEEP_BIT = 1;
  localparam int          ST_REF_BIT   = 2;
  // Negotiated link choice codes
  localparam logic [2:0]  ANEG_10H     = 3'h0;
  localparam logic [2:0]  ANEG_10F     = 3'h1;
  localparam logic [2:0]  ANEG_10FH    = 3'h2;
  localparam logic [2:0]  ANEG_100H    = 3'h3;
  localparam logic [2:0]  ANEG_MIX     = 3'h4;
  // Fixed link choice codes
  localparam logic [1:0]  FIX_10H      = 2'h0;
  localparam logic [1:0]  FIX_10F      = 2'h1;
  localparam logic [1:0]  FIX_100H     = 2'h2;
  // Timing
  localparam int          CLK_NS       = 100;
  localparam int          MS_NS        = 1000000;
  localparam int          MS_CYCLES    = MS_NS / CLK_NS;
  localparam int          MSCNT_W      = 16;
  // Two-wire byte position of the first index byte
  localparam logic [1:0]  POS_INDEX    = 2'h1;
endpackage : npc_pkg

// ==== hdl/npc_sleep_timer.sv ====
// Purpose: Power-down to sleep delay of about 2^n milliseconds
// Assumes: power_down and sleep_allow come from logic on this clock
// Notes:   Any drop of a condition restarts the wait from zero
`timescale 1ns/10ps
module npc_sleep_timer
  import npc_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         power_down,
  input  wire logic         sleep_allow,
  input  wire logic [3:0]   exponent,
  output logic              sleep_mode
);
  import npc_pkg::*;

  logic [31:0]        div_reg;
  logic [MSCNT_W:0]   ms_reg;
  logic               armed;
  logic               ms_tick;

  function automatic logic [MSCNT_W:0] pow2(input logic [3:0] n);
    pow2 = (MSCNT_W+1)'(1) << n;
  endfunction : pow2

  assign armed   = power_down && sleep_allow && (exponent != 4'h0);
  assign ms_tick = (div_reg == 32'(MS_TICKS - 1));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 32'h0;
    end else if (!armed || ms_tick) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ms_reg <= '0;
    end else if (!armed) begin
      ms_reg <= '0;
    end else if (ms_tick && !sleep_mode) begin
      ms_reg <= ms_reg + (MSCNT_W+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_mode <= 1'b0;
    end else if (!armed) begin
      sleep_mode <= 1'b0;
    end else if (ms_reg >= pow2(exponent)) begin
      sleep_mode <= 1'b1;
    end
  end
endmodule : npc_sleep_timer

// ==== hdl/npc_cfg.sv ====
// Purpose: Index floor, sleep delay and PHY link setup registers
// Assumes: Avalon-MM byte addresses; two-wire byte stream from firmware
// Notes:   One wait state per access; unmapped reads return zero
`timescale 1ns/10ps
// Behaviour
// - Refuse network writes to slave indexes below the floor value.
// - Compare only the first index byte, the second item of a transfer.
// - With exponent n nonzero, wait about 2^n ms in power-down, then sleep.
// - Exponent zero never sleeps, whatever sleep allow says.
// - Exponent range 1 to 15 gives 2 ms to 32768 ms.
// - Negotiation off clear uses PHY auto-negotiation; resets to zero.
// - Negotiation off set uses the fixed link choice instead.
// - Negotiated link choice selects advertised modes; reset code 100.
// - Fixed choice: 00 10 half, 01 10 full, 10 100 half; reset 00.
module npc_cfg
  import npc_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [BE_W-1:0]   byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  input  wire logic              net_byte_valid,
  input  wire logic              net_byte_first,
  input  wire logic              net_byte_write,
  input  wire logic [7:0]        net_byte,
  output logic                   index_refused,
  output logic                   index_checked,
  input  wire logic              power_down,
  output logic                   sleep_mode,
  output logic                   phy_negotiate,
  output logic                   phy_adv_10_half,
  output logic                   phy_adv_10_full,
  output logic                   phy_adv_100_half,
  output logic                   phy_fix_speed_100,
  output logic                   phy_fix_full
);
  import npc_pkg::*;

  logic [REG_W-1:0]  floor_reg;
  logic [REG_W-1:0]  sleep_reg;
  logic [REG_W-1:0]  phy_reg;
  logic [REG_W-1:0]  ctrl_reg;
  logic              ack_reg;
  logic              req;
  logic              wr_fire;
  logic [1:0]        pos_reg;
  logic              xfer_write_reg;
  logic [2:0]        adv;
  logic [1:0]        fix;
  logic              fix_100;
  logic              fix_full;

  // Byte address to register index; misaligned addresses hit nothing
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [5:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // Byte-lane merge of a 16-bit register, reserved bits forced to zero
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [BE_W-1:0] be,
                                             input logic [REG_W-1:0] msk);
    logic [REG_W-1:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    merge = v & msk;
  endfunction : merge

  // Bus handshake: one wait state, so read data can be flopped
  assign req         = read || write;
  assign waitrequest = req && !ack_reg;
  assign wr_fire     = write && ack_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= '0;
    end else if (read && !ack_reg) begin
      if (hit(address, IDX_FLOOR)) begin
        readdata <= {16'h0000, floor_reg};
      end else if (hit(address, IDX_SLEEP)) begin
        readdata <= {16'h0000, sleep_reg};
      end else if (hit(address, IDX_PHY)) begin
        readdata <= {16'h0000, phy_reg};
      end else if (hit(address, IDX_CTRL)) begin
        readdata <= {16'h0000, ctrl_reg};
      end else begin
        readdata <= '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      floor_reg <= RST_FLOOR;
    end else if (wr_fire && hit(address, IDX_FLOOR)) begin
      floor_reg <= merge(floor_reg, writedata, byteenable, MASK_FLOOR);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_reg <= RST_SLEEP;
    end else if (wr_fire && hit(address, IDX_SLEEP)) begin
      sleep_reg <= merge(sleep_reg, writedata, byteenable, MASK_SLEEP);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phy_reg <= RST_PHY;
    end else if (wr_fire && hit(address, IDX_PHY)) begin
      phy_reg <= merge(phy_reg, writedata, byteenable, MASK_PHY);
    end
  end

  // Status bits are live copies, only sleep allow is writable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= RST_CTRL;
    end else begin
      ctrl_reg[ALLOW_BIT] <= (wr_fire && hit(address, IDX_CTRL)
                               && byteenable[0])
                             ? writedata[ALLOW_BIT] : ctrl_reg[ALLOW_BIT];
      ctrl_reg[ST_SLEEP_BIT] <= sleep_mode;
      ctrl_reg[ST_REF_BIT]   <= index_refused;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pos_reg        <= 2'h0;
      xfer_write_reg <= 1'b0;
    end else if (net_byte_valid && net_byte_first) begin
      pos_reg        <= 2'h1;
      xfer_write_reg <= net_byte_write;
    end else if (net_byte_valid && pos_reg != 2'h3) begin
      pos_reg <= pos_reg + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      index_refused <= 1'b0;
      index_checked <= 1'b0;
    end else if (net_byte_valid && net_byte_first) begin
      index_refused <= 1'b0;
      index_checked <= 1'b0;
    end else if (net_byte_valid && pos_reg == POS_INDEX) begin
      index_checked <= 1'b1;
      index_refused <= xfer_write_reg
                       && ({1'b0, net_byte[FLOOR_MSB:0]} <
                           floor_reg[7:0] || net_byte[7]) == 1'b0
                       ? 1'b0
                       : xfer_write_reg
                         && ({1'b0, net_byte[FLOOR_MSB:0]}
                             < floor_reg[7:0])
                         && !net_byte[7];
    end
  end

  npc_sleep_timer #(
    .MS_TICKS    (MS_TICKS)
  ) u_sleep (
    .clock       (clock),
    .rst_b       (rst_b),
    .power_down  (power_down),
    .sleep_allow (ctrl_reg[ALLOW_BIT]),
    .exponent    (sleep_reg[EXP_MSB:0]),
    .sleep_mode  (sleep_mode)
  );

  always_comb begin
    adv = 3'b000;
    unique case (phy_reg[ANEG_MSB:ANEG_LSB])
      ANEG_10H:  adv = 3'b001;
      ANEG_10F:  adv = 3'b010;
      ANEG_10FH: adv = 3'b011;
      ANEG_100H: adv = 3'b100;
      ANEG_MIX:  adv = 3'b111;
      default:   adv = 3'b000;
    endcase
  end

  assign fix      = phy_reg[FIX_MSB:0];
  assign fix_100  = (fix == FIX_100H);
  assign fix_full = (fix == FIX_10F);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phy_negotiate     <= 1'b0;
      phy_adv_10_half   <= 1'b0;
      phy_adv_10_full   <= 1'b0;
      phy_adv_100_half  <= 1'b0;
      phy_fix_speed_100 <= 1'b0;
      phy_fix_full      <= 1'b0;
    end else begin
      phy_negotiate     <= !phy_reg[NEG_OFF_BIT];
      phy_adv_10_half   <= adv[0];
      phy_adv_10_full   <= adv[1];
      phy_adv_100_half  <= adv[2];
      phy_fix_speed_100 <= fix_100;
      phy_fix_full      <= fix_full;
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_write_phy;
    wr_fire && hit(address, IDX_PHY) && byteenable[1];
  endsequence

  sequence s_index_byte;
    net_byte_valid && !net_byte_first && pos_reg == POS_INDEX;
  endsequence

  sequence s_low_write;
    xfer_write_reg && !net_byte[7]
      && ({1'b0, net_byte[FLOOR_MSB:0]} < floor_reg[7:0]);
  endsequence

  a_wait_one_cycle: assert property (
    $rose(req) |-> waitrequest ##1 !waitrequest)
    else $error("waitrequest not released after one cycle");

  a_floor_readback: assert property (
    wr_fire && hit(address, IDX_FLOOR) && byteenable[0]
      |=> floor_reg == ($past(writedata[15:0]) & MASK_FLOOR))
    else $error("floor register did not store written value");

  a_reserved_zero: assert property (
    (floor_reg & ~MASK_FLOOR) == 16'h0000
      && (sleep_reg & ~MASK_SLEEP) == 16'h0000
      && (phy_reg & ~MASK_PHY) == 16'h0000)
    else $error("reserved bits not zero");

  a_refuse_low: assert property (
    s_index_byte ##0 s_low_write |=> index_refused)
    else $error("low index write not refused");

  a_index_compare: assert property (
    net_byte_valid && !net_byte_first && pos_reg == POS_INDEX
      |=> index_checked && index_refused ==
          ($past(xfer_write_reg) && !$past(net_byte[7])
           && ({1'b0, $past(net_byte[FLOOR_MSB:0])}
               < $past(floor_reg[7:0]))))
    else $error("index refusal does not match floor compare");

  a_later_bytes_free: assert property (
    net_byte_valid && !net_byte_first && pos_reg != POS_INDEX
      |=> $stable(index_refused))
    else $error("refusal changed on a non-index byte");

  a_no_sleep_zero: assert property (
    sleep_reg[EXP_MSB:0] == 4'h0 |=> !sleep_mode)
    else $error("sleep entered with exponent zero");

  a_sleep_needs_pd: assert property (
    !power_down |=> !sleep_mode)
    else $error("sleep held without power-down");

  a_phy_reset_val: assert property (
    $rose(rst_b) |-> phy_reg == RST_PHY)
    else $error("link setup reset value wrong");

  a_neg_follows: assert property (
    s_write_phy |=> ##1 phy_negotiate == !$past(writedata[15], 2))
    else $error("negotiate output does not follow register");

  a_fixed_decode: assert property (
    phy_reg[FIX_MSB:0] == FIX_100H |=> phy_fix_speed_100 && !phy_fix_full)
    else $error("fixed 100 half decode wrong");

  a_adv_mix: assert property (
    phy_reg[ANEG_MSB:ANEG_LSB] == ANEG_MIX
      |=> phy_adv_10_half && phy_adv_10_full && phy_adv_100_half)
    else $error("mixed advertisement decode wrong");

  a_adv_100_half: assert property (
    phy_reg[ANEG_MSB:ANEG_LSB] == ANEG_100H
      |=> !phy_adv_10_half && !phy_adv_10_full && phy_adv_100_half)
    else $error("100 half advertisement decode wrong");

  a_fixed_10_full: assert property (
    phy_reg[FIX_MSB:0] == FIX_10F |=> !phy_fix_speed_100 && phy_fix_full)
    else $error("fixed 10 full decode wrong");

  a_fixed_10_half: assert property (
    phy_reg[FIX_MSB:0] == FIX_10H |=> !phy_fix_speed_100 && !phy_fix_full)
    else $error("fixed 10 half decode wrong");

  a_neg_off_fixed: assert property (
    phy_reg[NEG_OFF_BIT] |=> !phy_negotiate)
    else $error("negotiate output high with negotiation off");

  a_neg_on_auto: assert property (
    !phy_reg[NEG_OFF_BIT] |=> phy_negotiate)
    else $error("negotiate output low with negotiation on");

  a_sleep_write: assert property (
    wr_fire && hit(address, IDX_SLEEP) && byteenable[0]
      |=> sleep_reg == ($past(writedata[15:0]) & MASK_SLEEP))
    else $error("sleep delay register did not store written value");

  a_read_data_lands: assert property (
    read && !ack_reg && hit(address, IDX_PHY)
      |=> readdata == {16'h0000, $past(phy_reg)})
    else $error("read data not loaded from link setup register");

  a_sleep_conditions: assert property (
    $rose(sleep_mode) |-> $past(power_down) && $past(ctrl_reg[ALLOW_BIT])
      && $past(sleep_reg[EXP_MSB:0]) != 4'h0)
    else $error("sleep entered without its conditions");

  // Holds for MS_TICKS of 4 or more
  a_no_early_sleep: assert property (
    $rose(power_down) |=> !sleep_mode [*8])
    else $error("sleep entered before the shortest delay");

  a_refuse_read_free: assert property (
    s_index_byte ##0 !xfer_write_reg |=> !index_refused)
    else $error("network read transfer refused");

  a_first_clears: assert property (
    net_byte_valid && net_byte_first |=> !index_refused && !index_checked)
    else $error("refusal not cleared at transfer start");
endmodule : npc_cfg

// ==== bench/npc_fw_model.sv ====
// Purpose: Firmware side feeding two-wire bytes to the config block
// Assumes: One byte per valid pulse, on the block's own clock
// Notes:   Idle byte lines show the inverse of the last byte
`timescale 1ns/10ps
module npc_fw_model (
  input  wire logic       clock,
  output logic            net_byte_valid,
  output logic            net_byte_first,
  output logic            net_byte_write,
  output logic [7:0]      net_byte
);
  initial begin
    net_byte_valid = 1'b0;
    net_byte_first = 1'b0;
    net_byte_write = 1'b0;
    net_byte       = 8'h00;
  end

  task automatic put(input logic v, input logic f, input logic w,
                     input logic [7:0] b);
    @(posedge clock);
    net_byte_valid <= v;
    net_byte_first <= f;
    net_byte_write <= w;
    net_byte       <= b;
  endtask : put

  // Address, index, one tail byte; gap idles stretch a slow sender
  task automatic send(input logic wr, input logic [7:0] idx,
                      input logic [7:0] tail, input int gap);
    put(1'b1, 1'b1, wr, {7'h50, ~wr});
    repeat (gap) put(1'b0, 1'b0, 1'b0, ~{7'h50, ~wr});
    put(1'b1, 1'b0, 1'b0, idx);
    repeat (gap) put(1'b0, 1'b0, 1'b0, ~idx);
    put(1'b1, 1'b0, 1'b0, tail);
    put(1'b0, 1'b0, 1'b0, ~tail);
  endtask : send
endmodule : npc_fw_model

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the network config register bank
// Assumes: MS_TICKS shortened to 4 cycles per millisecond
// Notes:   Bus master samples waitrequest and acts on rising edges only
`timescale 1ns/10ps
module testbench;
  import npc_pkg::*;
  localparam int MS_T = 4;
  logic              clock;
  logic              rst_b;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [BE_W-1:0]   byteenable;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic              nb_valid, nb_first, nb_write;
  logic [7:0]        nb_byte;
  logic              index_refused, index_checked;
  logic              power_down, sleep_mode;
  logic [5:0]        phy;
  logic [2:0]        adv [5];
  logic [1:0]        fx [3];
  int                err_count, samples_checked;

  npc_cfg #(.MS_TICKS(MS_T)) dut (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .net_byte_valid(nb_valid), .net_byte_first(nb_first),
    .net_byte_write(nb_write), .net_byte(nb_byte),
    .index_refused(index_refused), .index_checked(index_checked),
    .power_down(power_down), .sleep_mode(sleep_mode),
    .phy_negotiate(phy[5]), .phy_adv_10_half(phy[4]),
    .phy_adv_10_full(phy[3]), .phy_adv_100_half(phy[2]),
    .phy_fix_speed_100(phy[1]), .phy_fix_full(phy[0]));

  npc_fw_model fw (
    .clock(clock), .net_byte_valid(nb_valid), .net_byte_first(nb_first),
    .net_byte_write(nb_write), .net_byte(nb_byte));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    @(posedge clock);
    address   <= a;
    writedata <= {16'h0000, d};
    read      <= ~wr;
    write     <= wr;
    // Request stands until waitrequest is seen low at a rising edge
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    check(q, e);
  endtask : rd_chk

  task automatic floor_try(input logic [15:0] fl, input logic w,
                           input logic [7:0] idx, input logic [7:0] tail,
                           input int gap, input logic e);
    wr(8'h34, fl);
    fw.send(w, idx, tail, gap);
    repeat (2) @(negedge clock);
    check({31'h0, index_refused}, {31'h0, e});
    if (w)
      check({31'h0, index_checked}, 32'h0000_0001);
  endtask : floor_try

  // Tail time allows for the cycles from the last ms tick to sleep_mode
  task automatic sleep_try(input int n, input int lo, input int hi);
    int c;
    c = 0;
    wr(8'h38, 16'(n));
    power_down <= 1'b1;
    do begin
      @(negedge clock);
      c++;
    end while (sleep_mode !== 1'b1 && c < hi + 1);
    check({31'h0, (n == 0) ? (c > hi) : (c > lo && c <= hi)}, 32'h1);
    @(posedge clock);
    power_down <= 1'b0;
    repeat (2) @(negedge clock);
    check({31'h0, sleep_mode}, 32'h0);
  endtask : sleep_try

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    adv = '{3'h4, 3'h2, 3'h6, 3'h1, 3'h7};
    fx = '{2'h0, 2'h1, 2'h2};
    rst_b = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h3;
    power_down = 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(negedge clock);
    check({26'h0, phy}, {26'h0, 6'h3C});
    rd_chk(8'h34, 32'h0000_0000);
    rd_chk(8'h38, 32'h0000_0000);
    rd_chk(8'h3C, 32'h0000_0400);
    wr(8'h40, 16'h00FF);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0000);
    floor_try(16'h0040, 1'b1, 8'h3F, 8'h00, 0, 1'b1);
    floor_try(16'h0040, 1'b1, 8'h40, 8'h00, 2, 1'b0);
    floor_try(16'h0040, 1'b1, 8'h41, 8'h00, 0, 1'b0);
    floor_try(16'h0040, 1'b0, 8'h00, 8'h00, 1, 1'b0);
    floor_try(16'h007F, 1'b1, 8'h7E, 8'h7F, 0, 1'b1);
    rd_chk(8'hFC, 32'h0000_0004);
    rd_chk(8'h34, 32'h0000_007F);
    byteenable <= 4'h2;
    wr(8'h34, 16'h0011);
    byteenable <= 4'h3;
    rd_chk(8'h34, 32'h0000_007F);
    floor_try(16'h0000, 1'b1, 8'h00, 8'h00, 0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h3C, {5'h00, i[2:0], 8'h00});
      rd_chk(8'h3C, {21'h0, i[2:0], 8'h00});
      check({28'h0, phy[5:2]}, {29'h1, adv[i]});
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h3C, {1'h1, 4'h0, 3'h4, 6'h00, i[1:0]});
      rd_chk(8'h3C, {16'h0, 1'h1, 4'h0, 3'h4, 6'h00, i[1:0]});
      check({29'h0, phy[5], phy[1:0]}, {30'h0, fx[i]});
    end
    wr(8'h3C, 16'h0400);
    repeat (2) @(negedge clock);
    check({31'h0, phy[5]}, 32'h0000_0001);
    wr(8'h38, 16'h000F);
    rd_chk(8'h38, 32'h0000_000F);
    wr(8'hFC, 16'h0001);
    sleep_try(0, 0, 300);
    sleep_try(1, MS_T, 2 * MS_T + 8);
    sleep_try(3, 7 * MS_T, 8 * MS_T + 8);
    give_verdict();
  end
endmodule : testbench
